// >>> rtl/asc_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_OFF_CTRL1 8'h00
`define ASC_OFF_CTRL2 8'h01
`define ASC_OFF_CTRL3 8'h02
`define ASC_OFF_STAT1 8'h03
`define ASC_OFF_STAT2 8'h04
`define ASC_OFF_DATA 8'h05
`define ASC_OFF_BAUD 8'h06
`define ASC_OFF_CFG2 8'h1e
`define ASC_CTRL1_RST 8'h00
`define ASC_CTRL2_RST 8'h00
`define ASC_BAUD_RST 8'h00
`define ASC_CFG2_RST 8'h00
// Control register one fields
`define ASC_B_UNIT_EN 7
`define ASC_B_INV 5
`define ASC_B_CHAR9 4
// Control register two fields
`define ASC_B_TXE_IE 7
`define ASC_B_TC_IE 6
`define ASC_B_RXF_IE 5
`define ASC_B_TX_EN 3
`define ASC_B_RX_EN 2
`define ASC_B_SBK 0
// Control register three fields
`define ASC_B_RX9 7
`define ASC_B_TX9 6
// Status fields
`define ASC_B_TXE 7
`define ASC_B_TC 6
`define ASC_B_RXF 5
`define ASC_B_NF 3
`define ASC_B_FE 1
`define ASC_B_BRK 1
// Baud register fields and clock source bit
`define ASC_B_LONG 7
`define ASC_B_SRC 0
// Timing: sample ticks per bit, bus clock is one quarter of the crystal clock
`define ASC_TICKS_PER_BIT 16
`define ASC_BUS_DIV 4
`define ASC_LEN8 4'ha
`define ASC_LEN9 4'hb
// Sample positions, counter value is tick number minus one
`define ASC_RT3 4'h2
`define ASC_RT5 4'h4
`define ASC_RT7 4'h6
`define ASC_RT8 4'h7
`define ASC_RT9 4'h8
`define ASC_RT10 4'h9
`define ASC_RT16 4'hf
`endif

// >>> rtl/asc_pkg.sv
// Types shared by the serial unit
package asc_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SHIFT = 4'b0010,
    TX_BRK = 4'b0100,
    TX_TAIL = 4'b1000
  } asc_tx_e;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_BITS = 4'b0100,
    RX_XTRA = 4'b1000
  } asc_rx_e;
  typedef struct packed {
    logic brk;
    logic fe;
    logic nf;
    logic ninth;
    logic [7:0] data;
  } asc_rx_s;
endpackage

// >>> rtl/asc_tick_gen.sv
// Sample tick generator shared by transmitter and receiver
`timescale 1ns/100ps
`include "asc_defines.svh"
module asc_tick_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_src,
  input wire logic [5:0] i_div,
  output logic o_tick
);
  logic [1:0] pre_reg;
  logic [5:0] div_reg;
  wire step = i_bus_src ? (pre_reg == 2'(`ASC_BUS_DIV - 1)) : 1'b1;
  wire wrap = step && (div_reg >= i_div);

  // Bus clock source steps once per four crystal cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= 2'h0;
      div_reg <= 6'h00;
      o_tick <= 1'b0;
    end else begin
      pre_reg <= pre_reg + 2'h1;
      div_reg <= wrap ? 6'h00 : (step ? div_reg + 6'h01 : div_reg);
      o_tick <= wrap;
    end
  end
endmodule

// >>> rtl/asc_serial_unit.sv
// Asynchronous serial transmitter and receiver with byte register port
// Functional notes
// - Transmitter and receiver share one tick generator
// - Source bit picks bus or 4x clock
// - Nine-bit mode sends the tx ninth bit
// - Preamble of ones precedes buffered data
// - Zero start bit first, one stop last
// - Empty flag sets on buffer handoff, irq
// - Idle line level is one
// - Unit disable releases the pins at once
// - Break character is all zeros, sized
// - Breaks repeat; afterwards at least one one
// - Short break: ten or eleven zeros
// - Long break: eleven or twelve zeros
// - Break sets flags, clears data and ninth
// - Idle character all ones, sized, preamble
// - Tx disable finishes current character first
// - Tx re-enable queues an idle character
// - Inversion flips every transmitted level
// - Done flag: nothing buffered, shifting, or generated
// - Rx ninth bit, or copy of bit seven
// - Complete character loads buffer, sets full flag
// - Sixteen ticks per bit, resync on falling edges
// - Start is zero after three ones
// - Majority of ticks eight to ten, noise
// - Missing stop one sets frame fault
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
`include "asc_defines.svh"
module asc_serial_unit (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_RXD,
  output logic O_TXD,
  output logic O_TXD_OE,
  output logic O_TX_IRQ,
  output logic O_RX_IRQ
);
  logic [7:0] ctrl1_reg, ctrl2_reg, baud_reg, cfg2_reg, tx_buf_reg, rx_buf_reg;
  logic tx9_reg, rx9_reg, txe_reg, rxf_reg, fe_reg, nf_reg, brk_reg, arm_reg;
  logic tick;
  asc_pkg::asc_tx_e tx_state_reg;
  asc_pkg::asc_rx_e rx_state_reg;
  logic [10:0] tx_sr_reg;
  logic [3:0] tx_cnt_reg, tx_rt_reg;
  logic tx_pend_reg, tx_en_d_reg;
  logic rxd_s1_reg, rxd_s2_reg;
  logic [2:0] rx_hist_reg;
  logic [3:0] rx_rt_reg, rx_idx_reg;
  logic [8:0] rx_sr_reg;
  logic s_a_reg, s_b_reg, rx_nf_reg, rx_last_reg, rx_zero_reg;
  logic rx_done_reg;
  asc_pkg::asc_rx_s rx_res_reg;

  // Decoded control fields
  wire unit_en = ctrl1_reg[`ASC_B_UNIT_EN];
  wire tx_inv = ctrl1_reg[`ASC_B_INV];
  wire char9 = ctrl1_reg[`ASC_B_CHAR9];
  wire tx_en = ctrl2_reg[`ASC_B_TX_EN];
  wire rx_en = ctrl2_reg[`ASC_B_RX_EN];
  wire send_break_bit = ctrl2_reg[`ASC_B_SBK];
  wire long_brk = baud_reg[`ASC_B_LONG];
  wire [3:0] char_len = char9 ? `ASC_LEN9 : `ASC_LEN8;
  wire [3:0] brk_len = char_len + {3'h0, long_brk};

  // Register strobes
  wire wr_c1 = I_WR && (I_ADDR == `ASC_OFF_CTRL1);
  wire wr_c2 = I_WR && (I_ADDR == `ASC_OFF_CTRL2);
  wire wr_c3 = I_WR && (I_ADDR == `ASC_OFF_CTRL3);
  wire wr_dat = I_WR && (I_ADDR == `ASC_OFF_DATA);
  wire wr_bd = I_WR && (I_ADDR == `ASC_OFF_BAUD);
  wire wr_cf = I_WR && (I_ADDR == `ASC_OFF_CFG2);
  wire rd_s1 = I_RD && (I_ADDR == `ASC_OFF_STAT1);
  wire rd_s2 = I_RD && (I_ADDR == `ASC_OFF_STAT2);
  wire rd_dat = I_RD && (I_ADDR == `ASC_OFF_DATA);

  // Transmitter decisions; the starts of a frame are taken only in the idle state
  wire tx_bit = tick && (tx_rt_reg == `ASC_RT16);
  wire tx_idle = (tx_state_reg == asc_pkg::TX_IDLE);
  wire tx_go_pre = tx_idle && tx_en && tx_pend_reg;
  wire tx_go_brk = tx_idle && tx_en && !tx_pend_reg && send_break_bit;
  wire tx_go_data = tx_idle && tx_en && !tx_pend_reg && !send_break_bit && !txe_reg;
  wire tx_rise = tx_en && !tx_en_d_reg;
  wire tx_last = (tx_cnt_reg == 4'h1);
  wire tc_now = tx_idle && txe_reg && !tx_pend_reg && !(send_break_bit && tx_en);
  wire line_lvl = (tx_state_reg == asc_pkg::TX_SHIFT) ? tx_sr_reg[0] :
                  (tx_state_reg != asc_pkg::TX_BRK);
  // Start low at the LSB, stop high at the MSB; 8-bit frames pad with a one
  wire [10:0] frame = {1'b1, (char9 ? tx9_reg : 1'b1), tx_buf_reg, 1'b0};

  // Receiver sampling terms
  wire rxd = rxd_s2_reg;
  wire rx_tk = tick && rx_en && unit_en;
  wire maj = (s_a_reg & s_b_reg) | (s_a_reg & rxd) | (s_b_reg & rxd);
  wire noisy = !((s_a_reg == s_b_reg) && (s_b_reg == rxd));
  wire [3:0] nbits = char9 ? 4'h9 : 4'h8;
  wire at_stop = (rx_idx_reg == nbits);
  wire st_ok = ({s_a_reg, s_b_reg, rxd} == 3'b000) || ({s_a_reg, s_b_reg, rxd} == 3'b001) ||
               ({s_a_reg, s_b_reg, rxd} == 3'b010) || ({s_a_reg, s_b_reg, rxd} == 3'b100);
  wire resync = rx_last_reg && !rxd && (rx_rt_reg > `ASC_RT10) && (rx_rt_reg != `ASC_RT16)
                && !at_stop;
  wire brk_chr = rx_zero_reg && !maj;
  wire [7:0] rx_data = char9 ? rx_sr_reg[7:0] : rx_sr_reg[8:1];

  // Read data selection
  wire [7:0] st1 = {txe_reg, tc_now, rxf_reg, 1'b0, nf_reg, 1'b0, fe_reg, 1'b0};
  wire [7:0] rd_val =
    (I_ADDR == `ASC_OFF_CTRL1) ? ctrl1_reg :
    (I_ADDR == `ASC_OFF_CTRL2) ? ctrl2_reg :
    (I_ADDR == `ASC_OFF_CTRL3) ? {rx9_reg, tx9_reg, 6'h00} :
    (I_ADDR == `ASC_OFF_STAT1) ? st1 :
    (I_ADDR == `ASC_OFF_STAT2) ? {6'h00, brk_reg, 1'b0} :
    (I_ADDR == `ASC_OFF_DATA) ? rx_buf_reg :
    (I_ADDR == `ASC_OFF_BAUD) ? baud_reg :
    (I_ADDR == `ASC_OFF_CFG2) ? cfg2_reg : 8'h00;

  // One tick source for both directions, clock chosen by the source bit
  asc_tick_gen u_tick (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_bus_src(cfg2_reg[`ASC_B_SRC]),
    .i_div(baud_reg[5:0]),
    .o_tick(tick)
  );

  // Software registers; read data appears the cycle after the strobe
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl1_reg <= `ASC_CTRL1_RST;
      ctrl2_reg <= `ASC_CTRL2_RST;
      baud_reg <= `ASC_BAUD_RST;
      cfg2_reg <= `ASC_CFG2_RST;
      tx_buf_reg <= 8'h00;
      tx9_reg <= 1'b0;
      O_RDATA <= 8'h00;
    end else begin
      if (wr_c1) ctrl1_reg <= I_WDATA;
      if (wr_c2) ctrl2_reg <= I_WDATA;
      if (wr_bd) baud_reg <= I_WDATA;
      if (wr_cf) cfg2_reg <= I_WDATA;
      if (wr_c3) tx9_reg <= I_WDATA[`ASC_B_TX9];
      if (wr_dat) tx_buf_reg <= I_WDATA;
      O_RDATA <= I_RD ? rd_val : 8'h00;
    end
  end

  // Empty flag: status read arms, data write clears; a handoff always sets
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      txe_reg <= 1'b1;
      arm_reg <= 1'b0;
    end else begin
      if (tx_go_data) txe_reg <= 1'b1;
      else if (wr_dat && arm_reg) txe_reg <= 1'b0;
      if (rd_s1 && txe_reg) arm_reg <= 1'b1;
      else if (wr_dat) arm_reg <= 1'b0;
    end
  end

  // Transmit sequencer; a cleared enable is seen only in idle or at the end of a break, so a frame completes
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_state_reg <= asc_pkg::TX_IDLE;
      tx_sr_reg <= 11'h7ff;
      tx_cnt_reg <= 4'h0;
      tx_rt_reg <= 4'h0;
      tx_pend_reg <= 1'b0;
      tx_en_d_reg <= 1'b0;
    end else if (!unit_en) begin
      tx_state_reg <= asc_pkg::TX_IDLE;
      tx_pend_reg <= 1'b0;
      tx_en_d_reg <= 1'b0;
      tx_rt_reg <= 4'h0;
    end else begin
      tx_en_d_reg <= tx_en;
      if (tick) tx_rt_reg <= tx_rt_reg + 4'h1;
      case (tx_state_reg)
        asc_pkg::TX_IDLE: begin
          if (tx_rise) tx_pend_reg <= 1'b1;
          if (tx_go_pre) begin
            tx_sr_reg <= 11'h7ff;
            tx_cnt_reg <= char_len;
            tx_pend_reg <= tx_rise;
            tx_rt_reg <= 4'h0;
            tx_state_reg <= asc_pkg::TX_SHIFT;
          end else if (tx_go_brk) begin
            tx_cnt_reg <= brk_len;
            tx_rt_reg <= 4'h0;
            tx_state_reg <= asc_pkg::TX_BRK;
          end else if (tx_go_data) begin
            tx_sr_reg <= frame;
            tx_cnt_reg <= char_len;
            tx_rt_reg <= 4'h0;
            tx_state_reg <= asc_pkg::TX_SHIFT;
          end
        end
        asc_pkg::TX_SHIFT: begin
          if (tx_rise) tx_pend_reg <= 1'b1;
          if (tx_bit) begin
            tx_sr_reg <= {1'b1, tx_sr_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_last) tx_state_reg <= asc_pkg::TX_IDLE;
          end
        end
        asc_pkg::TX_BRK: begin
          if (tx_rise) tx_pend_reg <= 1'b1;
          if (tx_bit) begin
            tx_cnt_reg <= tx_cnt_reg - 4'h1;
            if (tx_last && send_break_bit && tx_en) tx_cnt_reg <= brk_len;
            else if (tx_last) tx_state_reg <= asc_pkg::TX_TAIL;
          end
        end
        asc_pkg::TX_TAIL: begin
          if (tx_rise) tx_pend_reg <= 1'b1;
          if (tx_bit) tx_state_reg <= asc_pkg::TX_IDLE;
        end
        default: tx_state_reg <= asc_pkg::TX_IDLE;
      endcase
    end
  end

  // Pin drive registered so glitches never reach the line
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TXD <= 1'b1;
      O_TXD_OE <= 1'b0;
      O_TX_IRQ <= 1'b0;
      O_RX_IRQ <= 1'b0;
    end else begin
      O_TXD <= line_lvl ^ tx_inv;
      O_TXD_OE <= unit_en && (tx_en || !tx_idle);
      O_TX_IRQ <= (txe_reg && ctrl2_reg[`ASC_B_TXE_IE]) ||
                  (tc_now && ctrl2_reg[`ASC_B_TC_IE]);
      O_RX_IRQ <= rxf_reg && ctrl2_reg[`ASC_B_RXF_IE];
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
    end else begin
      rxd_s1_reg <= I_RXD;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end

  // Receive sequencer, sixteen sample ticks per bit
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_state_reg <= asc_pkg::RX_IDLE;
      rx_hist_reg <= 3'h0;
      rx_rt_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sr_reg <= 9'h000;
      s_a_reg <= 1'b0;
      s_b_reg <= 1'b0;
      rx_nf_reg <= 1'b0;
      rx_last_reg <= 1'b0;
      rx_zero_reg <= 1'b0;
      rx_done_reg <= 1'b0;
      rx_res_reg <= '0;
    end else if (!(rx_en && unit_en)) begin
      rx_state_reg <= asc_pkg::RX_IDLE;
      rx_hist_reg <= 3'h0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (rx_tk) begin
        rx_rt_reg <= rx_rt_reg + 4'h1;
        if (rx_rt_reg == `ASC_RT3 || rx_rt_reg == `ASC_RT8) s_a_reg <= rxd;
        if (rx_rt_reg == `ASC_RT5 || rx_rt_reg == `ASC_RT9) s_b_reg <= rxd;
        case (rx_state_reg)
          asc_pkg::RX_IDLE: begin
            rx_hist_reg <= {rx_hist_reg[1:0], rxd};
            if (rx_hist_reg == 3'h7 && !rxd) begin
              rx_rt_reg <= 4'h1;
              rx_nf_reg <= 1'b0;
              rx_zero_reg <= 1'b1;
              rx_state_reg <= asc_pkg::RX_START;
            end
          end
          asc_pkg::RX_START: begin
            if (rx_rt_reg == `ASC_RT7) begin
              if (!st_ok) begin
                rx_hist_reg <= 3'h0;
                rx_state_reg <= asc_pkg::RX_IDLE;
              end else if (noisy) rx_nf_reg <= 1'b1;
            end
            if (rx_rt_reg > `ASC_RT7 && rx_rt_reg <= `ASC_RT10 && rxd) rx_nf_reg <= 1'b1;
            if (rx_rt_reg == `ASC_RT16) begin
              rx_idx_reg <= 4'h0;
              rx_last_reg <= 1'b0;
              rx_state_reg <= asc_pkg::RX_BITS;
            end
          end
          asc_pkg::RX_BITS: begin
            if (rx_rt_reg == `ASC_RT10) begin
              if (noisy) rx_nf_reg <= 1'b1;
              if (!at_stop) begin
                rx_sr_reg <= {maj, rx_sr_reg[8:1]};
                rx_last_reg <= maj;
                if (maj) rx_zero_reg <= 1'b0;
              end else if (brk_chr && long_brk) begin
                rx_state_reg <= asc_pkg::RX_XTRA;
              end else begin
                rx_done_reg <= 1'b1;
                rx_res_reg <= '{brk: brk_chr, fe: !maj, nf: rx_nf_reg || noisy,
                                ninth: rx_sr_reg[8], data: rx_data};
                rx_hist_reg <= 3'h0;
                rx_state_reg <= asc_pkg::RX_IDLE;
              end
            end
            if (resync) begin
              rx_rt_reg <= 4'h1;
              rx_last_reg <= 1'b0;
              rx_idx_reg <= rx_idx_reg + 4'h1;
            end else if (rx_rt_reg == `ASC_RT16) rx_idx_reg <= rx_idx_reg + 4'h1;
          end
          asc_pkg::RX_XTRA: begin
            if (rx_rt_reg == `ASC_RT10) begin
              rx_done_reg <= 1'b1;
              rx_res_reg <= '{brk: !maj, fe: 1'b1, nf: rx_nf_reg || noisy,
                              ninth: 1'b0, data: 8'h00};
              rx_hist_reg <= 3'h0;
              rx_state_reg <= asc_pkg::RX_IDLE;
            end
          end
          default: rx_state_reg <= asc_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Receive flags; a new character wins over a clearing read in the same cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_buf_reg <= 8'h00;
      rx9_reg <= 1'b0;
      rxf_reg <= 1'b0;
      fe_reg <= 1'b0;
      nf_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else if (rx_done_reg) begin
      rx_buf_reg <= rx_res_reg.brk ? 8'h00 : rx_res_reg.data;
      rx9_reg <= rx_res_reg.brk ? 1'b0 : rx_res_reg.ninth;
      rxf_reg <= 1'b1;
      fe_reg <= rx_res_reg.fe || fe_reg;
      nf_reg <= rx_res_reg.nf || nf_reg;
      brk_reg <= rx_res_reg.brk || brk_reg;
    end else begin
      if (rd_dat) begin
        rxf_reg <= 1'b0;
        fe_reg <= 1'b0;
        nf_reg <= 1'b0;
      end
      if (rd_s2) brk_reg <= 1'b0;
    end
  end

  chk_txd_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_idle && !tx_inv) |=> O_TXD) else $error("idle line not high");
  chk_txd_invert: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_idle && tx_inv) |=> !O_TXD) else $error("inverted idle not low");
  chk_break_low: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_state_reg == asc_pkg::TX_BRK && !tx_inv) |=> !O_TXD) else $error("break not low");
  chk_empty_set: assert property (@(posedge I_CLK) disable iff (I_RST)
    tx_go_data |=> txe_reg && tx_sr_reg[0] == 1'b0) else $error("handoff wrong");
  chk_pin_release: assert property (@(posedge I_CLK) disable iff (I_RST)
    !unit_en |=> !O_TXD_OE) else $error("pin kept driven");
  chk_rx_full: assert property (@(posedge I_CLK) disable iff (I_RST)
    rx_done_reg |=> rxf_reg && (fe_reg || !$past(rx_res_reg.fe))) else $error("no full");
  chk_break_flags: assert property (@(posedge I_CLK) disable iff (I_RST)
    (rx_done_reg && rx_res_reg.brk) |=> rx_buf_reg == 8'h00 && fe_reg && brk_reg && !rx9_reg)
    else $error("break flags wrong");
  chk_tail_one: assert property (@(posedge I_CLK) disable iff (I_RST)
    (tx_state_reg == asc_pkg::TX_TAIL && !tx_inv) |=> O_TXD) else $error("no trailing one");
endmodule

// >>> tb/asc_far_end.sv
// Far-end serial device model: drives the receive pin and times the transmit pin
`timescale 1ns/100ps
module asc_far_end (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  // Line idles high between frames
  initial o_rxd = 1'b1;

  // Bits go out lsb first, 16 cycles each; a long high gap lets the start search re-arm
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      o_rxd <= bits[i];
      repeat (16) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (64) @(posedge i_clk);
  endtask

  // Waits for the line to leave idle; negedge sampling keeps clear of the launch edge
  task automatic wait_low(input logic inv);
    for (int k = 0; k < 4000 && (i_txd ^ inv) !== 1'b0; k++) begin
      @(negedge i_clk);
    end
  endtask

  // Samples n cells mid-bit, starting with the start bit
  task automatic grab(input logic inv, input int n, output logic [11:0] bits);
    bits = 12'h000;
    wait_low(inv);
    repeat (8) @(negedge i_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = i_txd ^ inv;
      repeat (16) @(negedge i_clk);
    end
    // Hand back on a rising edge so bus tasks that follow stay aligned
    @(posedge i_clk);
  endtask

  // Counts the cycles of one low stretch, bounded so a stuck line cannot hang us
  task automatic low_run(output int c);
    c = 0;
    wait_low(1'b0);
    while (i_txd === 1'b0 && c < 4000) begin
      c++;
      @(negedge i_clk);
    end
    @(posedge i_clk);
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the serial unit
`timescale 1ns/100ps
`include "asc_defines.svh"
module tb;
  localparam int WD_CYCLES = 60000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic txd_oe;
  logic tx_irq;
  logic rx_irq;
  int err_count = 0;
  int n_tests = 0;
  logic [7:0] v;
  logic [11:0] fr;
  int c;

  // 100 MHz clock
  always #5 clk = ~clk;

  asc_serial_unit dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD(txd), .O_TXD_OE(txd_oe),
    .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq));
  asc_far_end far (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));

  // Register write, then one idle cycle so strobes never collide
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Register read: data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a, v);
    check({4'h0, v}, {4'h0, exp});
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    rd_chk(`ASC_OFF_CTRL1, 8'h00);
    rd_chk(`ASC_OFF_STAT1, 8'hc0);
    rd_chk(8'h10, 8'h00);
    check({10'h0, txd, txd_oe}, 12'h002);
    $display("test reset done");
  endtask

  // Data must wait in the buffer until the preamble has gone
  task automatic t_tx8();
    wr_reg(`ASC_OFF_CTRL1, 8'h80);
    wr_reg(`ASC_OFF_CTRL2, 8'h88);
    // A queued preamble already counts as work, so done reads low
    rd_chk(`ASC_OFF_STAT1, 8'h80);
    check({11'h0, tx_irq}, 12'h001);
    wr_reg(`ASC_OFF_DATA, 8'ha5);
    rd_chk(`ASC_OFF_STAT1, 8'h00);
    // Status is read while the data frame is still on the line
    fork
      far.grab(1'b0, 10, fr);
      begin
        repeat (200) @(posedge clk);
        rd_chk(`ASC_OFF_STAT1, 8'h80);
      end
    join
    check(fr, {3'b001, 8'ha5, 1'b0});
    check({11'h0, txd_oe}, 12'h001);
    repeat (40) @(posedge clk);
    rd_chk(`ASC_OFF_STAT1, 8'hc0);
    $display("test tx8 done");
  endtask

  task automatic t_tx9_inv();
    wr_reg(`ASC_OFF_CTRL1, 8'hb0);
    wr_reg(`ASC_OFF_CTRL3, 8'h40);
    check({11'h0, txd}, 12'h000);
    rd_chk(`ASC_OFF_STAT1, 8'hc0);
    wr_reg(`ASC_OFF_DATA, 8'h3c);
    far.grab(1'b1, 11, fr);
    check(fr, 12'h678);
    repeat (40) @(posedge clk);
    wr_reg(`ASC_OFF_CTRL3, 8'h00);
    wr_reg(`ASC_OFF_CTRL1, 8'h80);
    $display("test tx9 inverted done");
  endtask

  // Bus clock source slows each tick to four cycles; the start cell may be
  // short by a tick, so the full-length low cell of data bit one is timed
  task automatic t_src();
    wr_reg(`ASC_OFF_CFG2, 8'h01);
    rd_chk(`ASC_OFF_STAT1, 8'hc0);
    wr_reg(`ASC_OFF_DATA, 8'hfd);
    far.low_run(c);
    far.low_run(c);
    check(c[11:0], 12'h040);
    repeat (700) @(posedge clk);
    wr_reg(`ASC_OFF_CFG2, 8'h00);
    $display("test clock source done");
  endtask

  // Break length for each char size and long-break setting; first cell may lose one tick
  task automatic t_brk();
    logic [11:0] lens [4] = '{12'h0a0, 12'h0b0, 12'h0b0, 12'h0c0};
    for (int i = 0; i < 4; i++) begin
      wr_reg(`ASC_OFF_CTRL1, {3'b100, i[0], 4'h0});
      wr_reg(`ASC_OFF_BAUD, {i[1], 7'h00});
      wr_reg(`ASC_OFF_CTRL2, 8'h09);
      fork
        far.low_run(c);
        begin
          repeat (100) @(posedge clk);
          wr_reg(`ASC_OFF_CTRL2, 8'h08);
        end
      join
      check({11'h0, (lens[i] - c[11:0]) < 12'h002}, 12'h001);
      for (int k = 0; k < 16; k++) begin
        @(negedge clk);
        check({11'h0, txd}, 12'h001);
      end
      @(posedge clk);
    end
    wr_reg(`ASC_OFF_CTRL1, 8'h80);
    wr_reg(`ASC_OFF_BAUD, 8'h00);
    $display("test break send done");
  endtask

  task automatic t_rx();
    wr_reg(`ASC_OFF_CTRL2, 8'h2c);
    wr_reg(`ASC_OFF_CTRL1, 8'h90);
    far.send({1'b1, 1'b0, 8'h81, 1'b0}, 11);
    rd_chk(`ASC_OFF_CTRL3, 8'h00);
    rd_chk(`ASC_OFF_DATA, 8'h81);
    wr_reg(`ASC_OFF_CTRL1, 8'h80);
    far.send({3'b001, 8'h96, 1'b0}, 10);
    rd_chk(`ASC_OFF_STAT1, 8'he0);
    check({11'h0, rx_irq}, 12'h001);
    rd_chk(`ASC_OFF_CTRL3, 8'h80);
    rd_chk(`ASC_OFF_DATA, 8'h96);
    rd_chk(`ASC_OFF_STAT1, 8'hc0);
    $display("test receive done");
  endtask

  // Short break, too-short long break, long break, then a plain missing stop
  task automatic t_rxbrk();
    for (int i = 0; i < 3; i++) begin
      wr_reg(`ASC_OFF_BAUD, {i != 0, 7'h00});
      far.send(12'h000, 10 + i / 2);
      rd_chk(`ASC_OFF_STAT1, 8'he2);
      rd_chk(`ASC_OFF_CTRL3, 8'h00);
      rd_chk(`ASC_OFF_STAT2, {6'h00, i != 1, 1'b0});
      rd_chk(`ASC_OFF_DATA, 8'h00);
    end
    wr_reg(`ASC_OFF_BAUD, 8'h00);
    far.send({3'b000, 8'h55, 1'b0}, 10);
    rd_chk(`ASC_OFF_STAT1, 8'he2);
    rd_chk(`ASC_OFF_STAT2, 8'h00);
    rd_chk(`ASC_OFF_DATA, 8'h55);
    $display("test break receive done");
  endtask

  task automatic t_disable();
    wr_reg(`ASC_OFF_CTRL2, 8'h08);
    check({11'h0, txd_oe}, 12'h001);
    wr_reg(`ASC_OFF_CTRL1, 8'h00);
    repeat (2) @(posedge clk);
    check({11'h0, txd_oe}, 12'h000);
    $display("test disable done");
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tx8();
    t_tx9_inv();
    t_src();
    t_brk();
    t_rx();
    t_rxbrk();
    t_disable();
    give_verdict();
  end

  // Watchdog: several times the expected run length
  initial begin
    repeat (WD_CYCLES) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
